// *** reload_pwm_timer_consts.svh ***
`ifndef RELOAD_PWM_TIMER_CONSTS_SVH
`define RELOAD_PWM_TIMER_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define OFS_TIMER_CONTROL_STATUS 8'h00
`define OFS_COUNTER_ACCESS 8'h04
`define OFS_RELOAD_VALUE 8'h08
`define OFS_PWM_CHANNEL_CONTROL 8'h0c
`define OFS_DUTY_BUFFER0 8'h10
`define OFS_CAPTURE_CONTROL_STATUS 8'h20
`define OFS_CAPTURE_VALUE1 8'h24
`define OFS_CAPTURE_VALUE2 8'h28

// ------------------------------------------------------------------
// timer_control_status fields
// ------------------------------------------------------------------
`define POS_EXTERNAL_CLOCK_SELECT 7
`define POS_TAP_SELECT_HI 6
`define POS_TAP_SELECT_LO 4
`define POS_COUNT_ENABLE 3
`define POS_FORCE_RELOAD 2
`define POS_WRAP_IRQ_ENABLE 1
`define POS_WRAP_FLAG 0

// ------------------------------------------------------------------
// capture_control_status fields (channel 1 in the lower bit)
// ------------------------------------------------------------------
`define POS_CAPTURE_EDGE_SELECT 4
`define POS_CAPTURE_IRQ_ENABLE 2
`define POS_CAPTURE_FLAG 0

// ------------------------------------------------------------------
// pwm_channel_control fields
// ------------------------------------------------------------------
`define POS_PWM_PIN_ENABLE 4
`define POS_OUTPUT_POLARITY 0

// ------------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PRESCALER 7'h00
`define COUNTER_TOP 8'hff
`define PRESCALER_FULL 7'h7f

`endif

// *** reload_pwm_timer_pkg.sv ***
package reload_pwm_timer_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] presc_t;

endpackage

// *** capture_channel.sv ***
`timescale 1ns/1ps
`include "reload_pwm_timer_consts.svh"

module capture_channel (
    input wire logic clock,
    input wire logic rst,
    input wire logic capture_input_pin,
    input wire logic capture_edge_select,
    input wire logic halt_mode,
    input wire reload_pwm_timer_pkg::byte_t count_value,
    input wire logic flag_clear,
    output logic capture_flag,
    output reload_pwm_timer_pkg::byte_t capture_value,
    output logic wake_pulse
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic raw_prev_r;
    logic sync_edge;
    logic raw_edge;

    // ------------------------------------------------------------------
    // synchroniser and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            raw_prev_r <= 1'b0;
        end else begin
            sync1_r <= capture_input_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            raw_prev_r <= capture_input_pin;
        end
    end

    assign sync_edge = capture_edge_select ? (sync2_r & ~sync3_r) :
                       (~sync2_r & sync3_r);
    // halt wake path looks at the pin itself, no synchroniser delay
    assign raw_edge = capture_edge_select ?
                      (capture_input_pin & ~raw_prev_r) :
                      (~capture_input_pin & raw_prev_r);

    // ------------------------------------------------------------------
    // capture latch and flag
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_flag <= 1'b0;
            capture_value <= `RST_BYTE;
        end else begin
            // an edge while the flag is set is dropped; the clearing read wins
            if (sync_edge && !halt_mode && !capture_flag) begin
                capture_flag <= 1'b1;
                capture_value <= count_value;
            end else if (flag_clear) begin
                capture_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= halt_mode & raw_edge;
        end
    end

endmodule // capture_channel

// *** reload_pwm_timer.sv ***
`timescale 1ns/1ps
`include "reload_pwm_timer_consts.svh"

// How it works
// - 8-bit counter steps on each prescaler tick
// - overflow reloads counter, prescaler left alone
// - counter readable and writable while running
// - tap select n divides source by 2^n
// - source is cpu clock or external input
// - count enable clear freezes prescaler and counter
// - reset clears counter, prescaler, selects cpu
// - counter initialisation also clears the prescaler
// - compare shadows load from duty at overflow
// - pin enable drives pwm pin push-pull
// - pwm period is 256 minus reload counts
// - overflow sets inverse of polarity, compare restores polarity level
// - resolution one step in 256 minus reload
// - pwm generation stops during halt
// - overflow sets sticky flag, enabled interrupt
// - external events counted until overflow flag
// - selected capture edge latches counter, sets flag
// - captured channel blocked until value read
// - capture input synchronised over two edges
// - halt blocks latching, pin edge still wakes
// - polarity clear: high at or below compare
// - status read clears overflow flag
// - force reload reads zero, loads reload value
module reload_pwm_timer #(
    parameter int ADDR_WIDTH = 8,
    parameter int NUM_PWM = 4,
    parameter int NUM_CAPTURE = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_clock,
    input wire logic halt_mode,
    input wire logic [NUM_CAPTURE-1:0] capture_input_pin,
    output logic [NUM_PWM-1:0] pwm_output_pin,
    output logic [NUM_PWM-1:0] pwm_pin_enable,
    output logic wrap_irq,
    output logic [NUM_CAPTURE-1:0] capture_irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic external_clock_select_r;
    logic [2:0] prescale_tap_select_r;
    logic count_enable_bit_r;
    logic wrap_irq_enable_r;
    logic wrap_flag_r;
    reload_pwm_timer_pkg::byte_t reload_value_r;
    reload_pwm_timer_pkg::byte_t count_r;
    reload_pwm_timer_pkg::presc_t presc_r;
    logic [NUM_PWM-1:0] pwm_enable_r;
    logic [NUM_PWM-1:0] polarity_r;
    reload_pwm_timer_pkg::byte_t duty_buffer_r [NUM_PWM];
    reload_pwm_timer_pkg::byte_t compare_shadow_r [NUM_PWM];
    logic [NUM_CAPTURE-1:0] capture_edge_select_r;
    logic [NUM_CAPTURE-1:0] capture_irq_enable_r;
    logic [NUM_CAPTURE-1:0] capture_flag;
    logic [NUM_CAPTURE-1:0] capture_clear;
    logic [NUM_CAPTURE-1:0] wake_pulse;
    reload_pwm_timer_pkg::byte_t capture_value [NUM_CAPTURE];
    logic ext_prev_r;
    logic ext_rise;
    logic src_tick;
    logic running;
    reload_pwm_timer_pkg::presc_t tap_mask;
    logic count_tick;
    logic overflow;
    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic addr_hit;
    reload_pwm_timer_pkg::byte_t rd_value;
    logic car_write;
    logic force_reload;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = psel & penable & pready & ~pwrite;

    always_comb begin
        addr_hit = 1'b1;
        rd_value = `RST_BYTE;
        if (paddr == `OFS_TIMER_CONTROL_STATUS) begin
            rd_value = {external_clock_select_r, prescale_tap_select_r,
                        count_enable_bit_r, 1'b0,
                        wrap_irq_enable_r, wrap_flag_r};
        end else if (paddr == `OFS_COUNTER_ACCESS) begin
            rd_value = count_r;
        end else if (paddr == `OFS_RELOAD_VALUE) begin
            rd_value = reload_value_r;
        end else if (paddr == `OFS_PWM_CHANNEL_CONTROL) begin
            rd_value = {pwm_enable_r, polarity_r};
        end else if (paddr == `OFS_DUTY_BUFFER0) begin
            rd_value = duty_buffer_r[0];
        end else if (paddr == `OFS_DUTY_BUFFER0 + 8'h04) begin
            rd_value = duty_buffer_r[1];
        end else if (paddr == `OFS_DUTY_BUFFER0 + 8'h08) begin
            rd_value = duty_buffer_r[2];
        end else if (paddr == `OFS_DUTY_BUFFER0 + 8'h0c) begin
            rd_value = duty_buffer_r[3];
        end else if (paddr == `OFS_CAPTURE_CONTROL_STATUS) begin
            rd_value = {2'b00, capture_edge_select_r,
                        capture_irq_enable_r, capture_flag};
        end else if (paddr == `OFS_CAPTURE_VALUE1) begin
            rd_value = capture_value[0];
        end else if (paddr == `OFS_CAPTURE_VALUE2) begin
            rd_value = capture_value[1];
        end else begin
            addr_hit = 1'b0;
        end
    end

    // read data is frozen in setup so side effects match what was seen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~addr_hit;
            if (setup) begin
                prdata <= {24'h00_0000, rd_value};
            end
        end
    end

    assign car_write = wr_acc && paddr == `OFS_COUNTER_ACCESS;
    assign force_reload = wr_acc && paddr == `OFS_TIMER_CONTROL_STATUS &&
                          pwdata[`POS_FORCE_RELOAD];
    assign capture_clear[0] = rd_acc && paddr == `OFS_CAPTURE_VALUE1;
    assign capture_clear[1] = rd_acc && paddr == `OFS_CAPTURE_VALUE2;

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            external_clock_select_r <= 1'b0;
            prescale_tap_select_r <= 3'h0;
            count_enable_bit_r <= 1'b0;
            wrap_irq_enable_r <= 1'b0;
            reload_value_r <= `RST_BYTE;
            pwm_enable_r <= '0;
            polarity_r <= '0;
            capture_edge_select_r <= '0;
            capture_irq_enable_r <= '0;
            for (int i = 0; i < NUM_PWM; i++) begin
                duty_buffer_r[i] <= `RST_BYTE;
            end
        end else if (wr_acc) begin
            if (paddr == `OFS_TIMER_CONTROL_STATUS) begin
                external_clock_select_r <=
                    pwdata[`POS_EXTERNAL_CLOCK_SELECT];
                prescale_tap_select_r <=
                    pwdata[`POS_TAP_SELECT_HI:`POS_TAP_SELECT_LO];
                count_enable_bit_r <= pwdata[`POS_COUNT_ENABLE];
                wrap_irq_enable_r <= pwdata[`POS_WRAP_IRQ_ENABLE];
            end else if (paddr == `OFS_RELOAD_VALUE) begin
                reload_value_r <= pwdata[7:0];
            end else if (paddr == `OFS_PWM_CHANNEL_CONTROL) begin
                pwm_enable_r <= pwdata[`POS_PWM_PIN_ENABLE +: NUM_PWM];
                polarity_r <= pwdata[`POS_OUTPUT_POLARITY +: NUM_PWM];
            end else if (paddr >= `OFS_DUTY_BUFFER0 &&
                         paddr < `OFS_CAPTURE_CONTROL_STATUS &&
                         paddr[1:0] == 2'b00) begin
                duty_buffer_r[paddr[3:2]] <= pwdata[7:0];
            end else if (paddr == `OFS_CAPTURE_CONTROL_STATUS) begin
                capture_edge_select_r <=
                    pwdata[`POS_CAPTURE_EDGE_SELECT +: NUM_CAPTURE];
                capture_irq_enable_r <=
                    pwdata[`POS_CAPTURE_IRQ_ENABLE +: NUM_CAPTURE];
            end
        end
    end

    // ------------------------------------------------------------------
    // clock source and prescaler
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= external_count_clock;
        end
    end

    assign ext_rise = external_count_clock & ~ext_prev_r;
    // external input is unusable in halt; it is ignored there
    assign src_tick = external_clock_select_r ? ext_rise : 1'b1;
    assign running = count_enable_bit_r & ~halt_mode & src_tick;
    assign tap_mask = `PRESCALER_FULL >> (3'd7 - prescale_tap_select_r);
    assign count_tick = running && (presc_r & tap_mask) == tap_mask;
    assign overflow = count_tick && count_r == `COUNTER_TOP;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            presc_r <= `RST_PRESCALER;
        end else if (car_write || force_reload) begin
            presc_r <= `RST_PRESCALER;
        end else if (running) begin
            presc_r <= presc_r + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= `RST_BYTE;
        end else if (car_write) begin
            count_r <= pwdata[7:0];
        end else if (force_reload) begin
            count_r <= reload_value_r;
        end else if (overflow) begin
            count_r <= reload_value_r;
        end else if (count_tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_flag_r <= 1'b0;
        end else if (overflow) begin
            wrap_flag_r <= 1'b1;
        end else if (rd_acc && paddr == `OFS_TIMER_CONTROL_STATUS &&
                     prdata[`POS_WRAP_FLAG]) begin
            wrap_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // compare shadows and pwm pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PWM; i++) begin
                compare_shadow_r[i] <= `RST_BYTE;
            end
        end else if (overflow) begin
            for (int i = 0; i < NUM_PWM; i++) begin
                compare_shadow_r[i] <= duty_buffer_r[i];
            end
        end
    end

    // levels hold in halt; duty below reload is left to software
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_output_pin <= '0;
            pwm_pin_enable <= '0;
        end else if (!halt_mode) begin
            pwm_pin_enable <= pwm_enable_r;
            for (int i = 0; i < NUM_PWM; i++) begin
                pwm_output_pin[i] <= pwm_enable_r[i] &
                    ((count_r <= compare_shadow_r[i]) ^
                     polarity_r[i]);
            end
        end
    end

    // ------------------------------------------------------------------
    // capture channels
    // ------------------------------------------------------------------
    generate
        for (genvar c = 0; c < NUM_CAPTURE; c++) begin : g_cap
            capture_channel u_capture (
                .clock(clock),
                .rst(rst),
                .capture_input_pin(capture_input_pin[c]),
                .capture_edge_select(capture_edge_select_r[c]),
                .halt_mode(halt_mode),
                .count_value(count_r),
                .flag_clear(capture_clear[c]),
                .capture_flag(capture_flag[c]),
                .capture_value(capture_value[c]),
                .wake_pulse(wake_pulse[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_irq <= 1'b0;
            capture_irq <= '0;
        end else begin
            wrap_irq <= wrap_flag_r & wrap_irq_enable_r;
            capture_irq <= (capture_flag | wake_pulse) &
                           capture_irq_enable_r;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_STEP: assert property (@(posedge clock) disable iff (rst)
        count_tick && !overflow && !car_write && !force_reload
        |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not step by one");

    AST_RELOAD: assert property (@(posedge clock) disable iff (rst)
        overflow && !car_write && !force_reload
        |=> count_r == $past(reload_value_r) &&
            presc_r == $past(presc_r) + 7'h01)
        else $error("overflow reload wrong");

    AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
        !count_enable_bit_r && !car_write && !force_reload
        |=> $stable(count_r) && $stable(presc_r))
        else $error("counter moved while disabled");

    AST_PRESC_CLR: assert property (@(posedge clock) disable iff (rst)
        car_write || force_reload |=> presc_r == 7'h00)
        else $error("prescaler not cleared on init");

    AST_SHADOW: assert property (@(posedge clock) disable iff (rst)
        overflow |=> compare_shadow_r[0] == $past(duty_buffer_r[0]))
        else $error("compare shadow not loaded");

    AST_FLAG: assert property (@(posedge clock) disable iff (rst)
        overflow |=> wrap_flag_r ##1 (wrap_irq == $past(wrap_irq_enable_r)))
        else $error("overflow flag or interrupt missing");

    AST_FORCE_RELOAD_BIT_ZERO: assert property (@(posedge clock) disable iff (rst)
        pready && !pwrite && paddr == `OFS_TIMER_CONTROL_STATUS
        |-> !prdata[`POS_FORCE_RELOAD])
        else $error("force reload bit read as one");

    AST_CAP_HOLD: assert property (@(posedge clock) disable iff (rst)
        capture_flag[0] && !capture_clear[0]
        |=> capture_flag[0] && $stable(capture_value[0]))
        else $error("capture overwritten while flagged");

    AST_PWM_LVL: assert property (@(posedge clock) disable iff (rst)
        !halt_mode && pwm_enable_r[0] && !polarity_r[0]
        |=> pwm_output_pin[0] ==
            ($past(count_r) <= $past(compare_shadow_r[0])))
        else $error("pwm level does not follow compare");

    AST_HALT_PWM: assert property (@(posedge clock) disable iff (rst)
        halt_mode |=> $stable(pwm_output_pin))
        else $error("pwm changed during halt");

endmodule // reload_pwm_timer

// *** pwm_load_model.sv ***
`timescale 1ns/1ps
// ----
// pwm loads: cycles each pin is driven high
// ----
module pwm_load_model (
    input wire logic clock,
    input wire logic clr,
    input wire logic [3:0] pwm_output_pin,
    input wire logic [3:0] pwm_pin_enable,
    output int high_cnt [4]
);
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (clr) begin
                high_cnt[i] <= 0;
            end else if (pwm_pin_enable[i] && pwm_output_pin[i]) begin
                high_cnt[i] <= high_cnt[i] + 1;
            end
        end
    end
endmodule // pwm_load_model

// *** reload_pwm_timer_tb_top.sv ***
`timescale 1ns/1ps
module reload_pwm_timer_tb_top;
    logic clock, rst, psel, penable, pwrite, ext, halt, clr;
    logic pready, pslverr, er, wrap_irq;
    logic [7:0] paddr, c0;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [1:0] cap_pin, capture_irq;
    logic [3:0] pwm, pen, pol, pwm_hold;
    logic [7:0] duty [4];
    int high_cnt [4];
    int n_fail, compares, cyc, t0, wake_cnt, h;
    reload_pwm_timer dut_u (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_clock(ext), .halt_mode(halt),
        .capture_input_pin(cap_pin), .pwm_output_pin(pwm),
        .pwm_pin_enable(pen), .wrap_irq(wrap_irq), .capture_irq(capture_irq));
    pwm_load_model load_u (.clock(clock), .clr(clr), .pwm_output_pin(pwm),
        .pwm_pin_enable(pen), .high_cnt(high_cnt));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (halt && capture_irq[1]) wake_cnt <= wake_cnt + 1;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input int e, input logic [31:0] g,
                       input int t);
        compares++;
        if ((^g === 1'bx) || (int'(g) - e > t) || (e - int'(g) > t)) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input int e, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd, 0);
    endtask
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {psel, penable, pwrite, ext, halt, clr} = 6'h0;
        {paddr, pwdata, cap_pin} = '0;
        {n_fail, compares, cyc, wake_cnt} = '0;
        seed = 32'h8f32c9b5;
        rst = 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) rdc(8'(i * 4), 0, "reset");
        apb(1'b0, 8'h2c, 32'h0);
        chk("slverr", 1, {31'h0, er}, 0);
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h00, 32'((n << 4) | 8));
            apb(1'b0, 8'h04, 32'h0);
            c0 = rd[7:0];
            t0 = cyc;
            repeat (120) @(posedge clock);
            apb(1'b0, 8'h04, 32'h0);
            chk("tap", (cyc - t0) >> n, {24'h0, rd[7:0] - c0}, 1);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h55);
        repeat (30) @(posedge clock);
        rdc(8'h04, 8'h55, "frozen");
        apb(1'b1, 8'h08, 32'hf0);
        apb(1'b1, 8'h04, 32'hfe);
        apb(1'b1, 8'h00, 32'h0a);
        repeat (20) @(posedge clock);
        apb(1'b1, 8'h00, 32'h02);
        chk("wrap_irq", 1, {31'h0, wrap_irq}, 0);
        rdc(8'h00, 8'h03, "flag set");
        rdc(8'h00, 8'h02, "flag cleared");
        chk("wrap_irq", 0, {31'h0, wrap_irq}, 0);
        apb(1'b0, 8'h04, 32'h0);
        chk("reloaded", 15, {28'h0, rd[7:4]}, 0);
        apb(1'b1, 8'h08, 32'h80);
        apb(1'b1, 8'h00, 32'h04);
        rdc(8'h04, 8'h80, "force reload");
        rdc(8'h00, 8'h00, "force bit");
        apb(1'b1, 8'h08, 32'hfc);
        apb(1'b1, 8'h00, 32'h84);
        apb(1'b1, 8'h00, 32'h88);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) rdc(8'h00, 8'h88, "three events");
            ext <= 1'b1;
            repeat (4) @(posedge clock);
            ext <= 1'b0;
            repeat (4) @(posedge clock);
        end
        rdc(8'h00, 8'h89, "four events");
        apb(1'b1, 8'h08, 32'hc0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            duty[i] = 8'hc1 | {2'b00, seed[5:0]};
            apb(1'b1, 8'(8'h10 + i * 4), {24'h0, duty[i]});
        end
        seed = xs(seed);
        pol = seed[3:0];
        apb(1'b1, 8'h0c, {24'h0, 4'hf, pol});
        apb(1'b1, 8'h00, 32'h08);
        repeat (200) @(posedge clock);
        chk("pin enable", 15, {28'h0, pen}, 0);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        repeat (640) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            h = duty[i] - 8'hbf;
            h = pol[i] ? 64 - h : h;
            chk("pwm high", h * 10, high_cnt[i], 2);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h3c);
        apb(1'b1, 8'h20, 32'h1c);
        cap_pin <= 2'b11;
        repeat (6) @(posedge clock);
        chk("capture_irq", 1, {30'h0, capture_irq}, 0);
        apb(1'b1, 8'h04, 32'h11);
        cap_pin <= 2'b00;
        repeat (6) @(posedge clock);
        cap_pin <= 2'b01;
        repeat (6) @(posedge clock);
        rdc(8'h20, 8'h1f, "capture flags");
        rdc(8'h24, 8'h3c, "capture one");
        rdc(8'h28, 8'h11, "capture two");
        rdc(8'h20, 8'h1c, "flags cleared");
        apb(1'b1, 8'h00, 32'h00);
        halt <= 1'b1;
        cap_pin <= 2'b11;
        repeat (4) @(posedge clock);
        pwm_hold = pwm;
        chk("no wake", 0, wake_cnt, 0);
        // flipped polarity must not reach the pins while halted
        apb(1'b1, 8'h0c, {24'h0, 4'hf, ~pol});
        cap_pin <= 2'b01;
        repeat (40) @(posedge clock);
        chk("wake", 1, wake_cnt, 0);
        chk("pwm halted", pwm_hold, {28'h0, pwm}, 0);
        halt <= 1'b0;
        rdc(8'h20, 8'h1c, "halt no capture");
        conclude();
    end
endmodule // reload_pwm_timer_tb_top
